// ===== hdl/lock_detect_defines.vh
// constants for the digital lock detect block
`ifndef LOCK_DETECT_DEFINES_VH
`define LOCK_DETECT_DEFINES_VH
`define WINDOW_WIDTH     8
`define COUNT_WIDTH      20
`define ERR_WIDTH        16
`define DETECT_WAIT      2'h0
`define DETECT_MEASURE   2'h1
`define DETECT_DONE      2'h2
`endif

// ===== hdl/edge_window_counter.v
// one in-window comparison counter for one lock event
`timescale 1ns/1ps
`include "lock_detect_defines.vh"
module edge_window_counter #(
  parameter CW = `COUNT_WIDTH
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst,
  // comparison result
  input  wire          cmp_valid,
  input  wire          cmp_in_window,
  input  wire [CW-1:0] lock_count,
  // result
  output reg           event_r
);

  reg [CW-1:0] count_r;

  // ---------------------------------------
  // count consecutive in-window comparisons
  // ---------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      count_r <= {CW{1'b0}};
      event_r <= 1'b0;
    end else if (cmp_valid) begin
      if (!cmp_in_window) begin
        count_r <= {CW{1'b0}};
        event_r <= 1'b0;
      end else if (count_r < lock_count) begin
        count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
        // event first set on the lock_count-th good cycle
        event_r <= (count_r + {{(CW-1){1'b0}}, 1'b1} >= lock_count);
      end else begin
        event_r <= 1'b1;
      end
    end
  end

endmodule // edge_window_counter

// ===== hdl/lock_detect.v
// dual loop digital lock detect with holdover exit
`timescale 1ns/1ps
`include "lock_detect_defines.vh"
module lock_detect #(
  parameter WW = `WINDOW_WIDTH,
  parameter CW = `COUNT_WIDTH,
  parameter EW = `ERR_WIDTH
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst,
  // loop 1 divider outputs (pins)
  input  wire          loop1_reference_divider_out,
  input  wire          loop1_feedback_divider_out,
  // loop 2 divider outputs (pins)
  input  wire          loop2_reference_divider_out,
  input  wire          loop2_feedback_divider_out,
  // configuration
  input  wire [WW-1:0] loop1_lock_window,
  input  wire [CW-1:0] loop1_lock_count,
  input  wire [WW-1:0] loop2_lock_window,
  input  wire [CW-1:0] loop2_lock_count,
  input  wire [CW-1:0] holdover_exit_count,
  input  wire          holdover_enter,
  // status
  output reg           loop1_lock_detected_r,
  output reg           loop2_lock_detected_r,
  output reg           holdover_active_r
);

  wire l1_valid;
  wire l1_in;
  wire l2_valid;
  wire l2_in;
  wire l1_event;
  wire l2_event;
  wire hold_event;

  // -----------------------------------------------
  // per-loop edge comparison (one per pd cycle)
  // -----------------------------------------------
  // window in clock cycles; edges sampled so resolution is one 40 ns cycle
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : loop_cmp
      wire [WW-1:0] window = (g == 0) ? loop1_lock_window : loop2_lock_window;
      wire          ref_pin = (g == 0) ? loop1_reference_divider_out
                                       : loop2_reference_divider_out;
      wire          fb_pin  = (g == 0) ? loop1_feedback_divider_out
                                       : loop2_feedback_divider_out;
      reg  [2:0]    ref_s_r;
      reg  [2:0]    fb_s_r;
      reg           ref_lvl_r;
      reg           fb_lvl_r;
      reg           ref_seen_r;
      reg           fb_seen_r;
      reg  [EW-1:0] err_r;
      reg           valid_r;
      reg           in_r;
      wire          ref_rise;
      wire          fb_rise;
      wire          ref_now;
      wire          fb_now;
      wire          both;
      wire          waiting;
      wire [EW-1:0] err_now;
      wire          in_window;
      // three flops; a change counts once the second and third agree
      assign ref_now   = (ref_s_r[1] == ref_s_r[2]) ? ref_s_r[2] : ref_lvl_r;
      assign fb_now    = (fb_s_r[1] == fb_s_r[2]) ? fb_s_r[2] : fb_lvl_r;
      assign ref_rise  = ref_now & ~ref_lvl_r;
      assign fb_rise   = fb_now & ~fb_lvl_r;
      assign both      = (ref_seen_r | ref_rise) & (fb_seen_r | fb_rise);
      assign waiting   = ref_seen_r | ref_rise | fb_seen_r | fb_rise;
      // edges in the same cycle are zero apart
      assign err_now   = (ref_rise & fb_rise) ? {EW{1'b0}} : err_r;
      // a spacing equal to the window still counts as inside
      assign in_window = (err_now <= {{(EW-WW){1'b0}}, window});

      // ---------------------------------------------
      // pin synchronisers and settled levels
      // ---------------------------------------------
      // reset levels match idle-low pins, so no false edge after reset
      always @(posedge clock) begin
        if (rst) begin
          ref_s_r   <= 3'h0;
          fb_s_r    <= 3'h0;
          ref_lvl_r <= 1'b0;
          fb_lvl_r  <= 1'b0;
        end else begin
          ref_s_r   <= {ref_s_r[1:0], ref_pin};
          fb_s_r    <= {fb_s_r[1:0], fb_pin};
          ref_lvl_r <= ref_now;
          fb_lvl_r  <= fb_now;
        end
      end

      // ---------------------------------------------
      // edge pairing
      // ---------------------------------------------
      // a second edge of one side before the other arrives is merged
      always @(posedge clock) begin
        if (rst) begin
          ref_seen_r <= 1'b0;
          fb_seen_r  <= 1'b0;
        end else if (both) begin
          ref_seen_r <= 1'b0;
          fb_seen_r  <= 1'b0;
        end else begin
          ref_seen_r <= ref_seen_r | ref_rise;
          fb_seen_r  <= fb_seen_r | fb_rise;
        end
      end

      // ---------------------------------------------
      // spacing counter between the two edges of a pair
      // ---------------------------------------------
      // saturates so a lost edge reads as far outside any window
      always @(posedge clock) begin
        if (rst) begin
          err_r <= {EW{1'b0}};
        end else if (both) begin
          err_r <= {EW{1'b0}};
        end else if (waiting && (err_r != {EW{1'b1}})) begin
          err_r <= err_r + {{(EW-1){1'b0}}, 1'b1};
        end
      end

      // ---------------------------------------------
      // one comparison result per completed pair
      // ---------------------------------------------
      always @(posedge clock) begin
        if (rst) begin
          valid_r <= 1'b0;
          in_r    <= 1'b0;
        end else begin
          valid_r <= both;
          if (both)
            in_r <= in_window;
        end
      end
    end
  endgenerate

  assign l1_valid = loop_cmp[0].valid_r;
  assign l1_in    = loop_cmp[0].in_r;
  assign l2_valid = loop_cmp[1].valid_r;
  assign l2_in    = loop_cmp[1].in_r;

  // -----------------------------------------------
  // three event counters
  // -----------------------------------------------
  // holdover exit reuses the loop 1 comparison, with its own count
  // a lock count of zero fires on the first in-window compare
  edge_window_counter #(.CW(CW)) u_loop1 (
    .clock         (clock),
    .rst           (rst),
    .cmp_valid     (l1_valid),
    .cmp_in_window (l1_in),
    .lock_count    (loop1_lock_count),
    .event_r       (l1_event)
  );

  edge_window_counter #(.CW(CW)) u_loop2 (
    .clock         (clock),
    .rst           (rst),
    .cmp_valid     (l2_valid),
    .cmp_in_window (l2_in),
    .lock_count    (loop2_lock_count),
    .event_r       (l2_event)
  );

  edge_window_counter #(.CW(CW)) u_holdover (
    .clock         (clock),
    .rst           (rst),
    .cmp_valid     (l1_valid),
    .cmp_in_window (l1_in),
    .lock_count    (holdover_exit_count),
    .event_r       (hold_event)
  );

  // -----------------------------------------------
  // lock indications
  // -----------------------------------------------
  // follow the counters, so a cleared count drops the indication too
  always @(posedge clock) begin
    if (rst) begin
      loop1_lock_detected_r <= 1'b0;
      loop2_lock_detected_r <= 1'b0;
    end else begin
      loop1_lock_detected_r <= l1_event;
      loop2_lock_detected_r <= l2_event;
    end
  end

  // -----------------------------------------------
  // holdover mode
  // -----------------------------------------------
  // exit wins over a simultaneous entry request, and keeps winning
  // while the exit count stays met
  always @(posedge clock) begin
    if (rst) begin
      holdover_active_r <= 1'b0;
    end else if (hold_event) begin
      holdover_active_r <= 1'b0;
    end else if (holdover_enter) begin
      holdover_active_r <= 1'b1;
    end
  end

endmodule // lock_detect

// ===== bench/lock_detect_props.sv
// assertions on the lock detect ports
`timescale 1ns/1ps
module lock_detect_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control and status
  input wire logic holdover_enter,
  input wire logic loop1_lock_detected_r,
  input wire logic loop2_lock_detected_r,
  input wire logic holdover_active_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rst;
    disable iff (1'b0) rst |=> !loop1_lock_detected_r && !loop2_lock_detected_r
      && !holdover_active_r;
  endproperty
  a_rst: assert property (p_rst) else $error("output set in reset");
  property p_hold_rise;
    $rose(holdover_active_r) |-> $past(holdover_enter);
  endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("holdover without enter");
  property p_l1_early;
    $fell(rst) |-> !loop1_lock_detected_r [*4];
  endproperty
  a_l1_early: assert property (p_l1_early) else $error("loop1 locked too soon");
  property p_l2_early;
    $fell(rst) |-> !loop2_lock_detected_r [*4];
  endproperty
  a_l2_early: assert property (p_l2_early) else $error("loop2 locked too soon");
  property p_l1_rise;
    $rose(loop1_lock_detected_r) |=> loop1_lock_detected_r;
  endproperty
  a_l1_rise: assert property (p_l1_rise) else $error("loop1 lock glitch");
  property p_l1_fall;
    $fell(loop1_lock_detected_r) |=> !loop1_lock_detected_r;
  endproperty
  a_l1_fall: assert property (p_l1_fall) else $error("loop1 unlock glitch");
  property p_l2_rise;
    $rose(loop2_lock_detected_r) |=> loop2_lock_detected_r;
  endproperty
  a_l2_rise: assert property (p_l2_rise) else $error("loop2 lock glitch");
  property p_l2_fall;
    $fell(loop2_lock_detected_r) |=> !loop2_lock_detected_r;
  endproperty
  a_l2_fall: assert property (p_l2_fall) else $error("loop2 unlock glitch");
endmodule // lock_detect_props
bind lock_detect lock_detect_props chk (.clock(clock), .rst(rst),
  .holdover_enter(holdover_enter), .loop1_lock_detected_r(loop1_lock_detected_r),
  .loop2_lock_detected_r(loop2_lock_detected_r), .holdover_active_r(holdover_active_r));

// ===== bench/divider_model.sv
// divided reference and feedback pulses, 16 clock period
`timescale 1ns/1ps
module divider_model (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [7:0] skew,
  output reg              ref_out,
  output reg              fb_out
);
  reg [7:0] n_r;
  // stopped dividers sit low, so no stray rising edge
  always @(posedge clock) begin
    n_r     <= run ? n_r + 8'h01 & 8'h0F : 8'h00;
    ref_out <= run && n_r < 8'h04;
    fb_out  <= run && n_r >= skew && n_r < skew + 8'h04;
  end
endmodule // divider_model

// ===== bench/test_lock_detect.sv
// self-checking testbench for lock_detect
`timescale 1ns/1ps
module test_lock_detect;
  reg        clock = 0, rst = 1, run1 = 0, run2 = 0, hold_in = 0;
  reg [7:0]  skew1 = 8'h01, skew2 = 8'h01, win = 8'h02;
  reg [19:0] cnt1 = 20'h00004, cnt2 = 20'h00006, hcnt = 20'h00003;
  wire       r1, f1, r2, f2, lk1, lk2, hold;
  integer    n_mismatch = 0, total_checks = 0;
  initial forever #20 clock = ~clock;
  divider_model m1 (.clock(clock), .run(run1), .skew(skew1), .ref_out(r1), .fb_out(f1));
  divider_model m2 (.clock(clock), .run(run2), .skew(skew2), .ref_out(r2), .fb_out(f2));
  lock_detect uut (.clock(clock), .rst(rst), .loop1_reference_divider_out(r1),
    .loop1_feedback_divider_out(f1), .loop2_reference_divider_out(r2),
    .loop2_feedback_divider_out(f2), .loop1_lock_window(win), .loop1_lock_count(cnt1),
    .loop2_lock_window(win), .loop2_lock_count(cnt2), .holdover_exit_count(hcnt),
    .holdover_enter(hold_in), .loop1_lock_detected_r(lk1),
    .loop2_lock_detected_r(lk2), .holdover_active_r(hold));
  function logic pick(input integer s);
    pick = s == 1 ? lk1 : s == 2 ? lk2 : hold;
  endfunction
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input integer s, input logic v);
    total_checks++;
    if (pick(s) !== v) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, pick(s), v);
    end
  endtask
  task idle(input integer k);
    repeat (k) @(negedge clock);
  endtask
  // bounded wait; a miss ends the run
  task await(input integer s, input logic v, input integer lim);
    integer i;
    for (i = 0; i < lim && pick(s) !== v; i++) @(negedge clock);
    check(s, v);
    if (pick(s) !== v) conclude;
  endtask
  task t_lock1;
    run1 = 1;
    idle(40);
    check(1, 0);
    await(1, 1, 60);
  endtask
  task t_unlock1;
    skew1 = 8'h03;
    await(1, 0, 40);
    skew1 = 8'h02;
    idle(30);
    check(1, 0);
    await(1, 1, 100);
  endtask
  task t_lock2;
    run2 = 1;
    idle(70);
    check(2, 0);
    await(2, 1, 60);
  endtask
  // exit count stays met while loop 1 is locked, so break the lock first
  task t_hold;
    skew1 = 8'h03;
    await(1, 0, 40);
    run1 = 0;
    hold_in = 1;
    await(3, 1, 5);
    skew1 = 8'h02;
    run1 = 1;
    idle(20);
    check(3, 1);
    await(3, 0, 60);
  endtask
  initial begin
    idle(16);
    rst = 0;
    check(1, 0);
    check(3, 0);
    t_lock1;
    t_unlock1;
    t_lock2;
    t_hold;
    conclude;
  end
endmodule // test_lock_detect
